//--- hw/rst_cfg_pkg.sv
// Constants, types and the register map of the reset pin and strap latch.
// Assumes a single 50 MHz clock domain and an APB register port.
package rst_cfg_pkg;
  // ==========================================================
  // Timing counts, in pclk cycles
  localparam int QUAL_CYC = 10;
  localparam int GLITCH_MIN_CYC = 2;
  localparam int RESET_OUT_N_DELAY_CYC = 2;
  localparam int RESET_OUT_N_LEN_CYC = 16;
  localparam int WAKE_LEAD_CYC = 4;
  localparam int CNT_W = 8;
  // ==========================================================
  // Register offsets and field positions
  localparam logic [7:0] STATUS_OFF = 8'h00;
  localparam logic [7:0] CTRL_OFF = 8'h04;
  localparam int B_WAKE = 0;
  localparam int B_BOOT = 1;
  localparam int B_DBG = 2;
  localparam int B_GLITCH = 3;
  localparam int B_SRC = 4;
  localparam int B_OSC = 7;
  localparam int B_BUSY = 8;
  localparam int C_SW_SYS = 0;
  localparam int C_SW_EXT = 1;
  // ==========================================================
  // Reset values and encodings
  localparam logic WAKE_RST = 1'b0;
  localparam logic BOOT_RST = 1'b0;
  localparam logic DBG_RST = 1'b0;
  localparam logic BOOT_FLASH = 1'b0;
  localparam logic BOOT_SERIAL = 1'b1;
  typedef enum logic [2:0] {SRC_POR, SRC_EXT, SRC_SW_SYS, SRC_SW_EXT, SRC_DBG} src_t;
  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_ASSERT} seq_t;
  typedef struct packed {
    logic rst_n;
    logic wake;
    logic boot;
    logic evt;
    logic osc;
  } pins_t;
endpackage : rst_cfg_pkg

//--- hw/reset_pin_and_config_latch.sv
// Reset pin qualification, reset output sequencing and strap latching.
// Assumes the pins are asynchronous to pclk and software sits on APB.
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Internal reset after ten consecutive low cycles.
// - Reset input during reset restarts sequence.
// - Flag low spikes longer than two cycles.
// - Drive reset output low for every source.
// - Reset output asserts after a delay.
// - Sample wake strap four cycles before negation.
// - Store wake strap except debug, software-external resets.
// - Wake strap selects pull-up or pull-down.
// - Sample boot strap while reset output low.
// - Boot value 0 flash, 1 serial.
// - Latch debug enable at reset negation.
// - Debug event after reset requests sync.
// - Trace bit high until oscillator stable.
module reset_pin_and_config_latch #(
  parameter int QUAL = rst_cfg_pkg::QUAL_CYC,
  parameter int LEN = rst_cfg_pkg::RESET_OUT_N_LEN_CYC
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins from the board
  input wire logic reset_in_n,
  input wire logic wake_pull_strap,
  input wire logic boot_cfg_strap,
  input wire logic debug_event_in,
  input wire logic osc_stable_in,
  // Request from the debug port logic
  input wire logic dbg_port_reset_req,
  // Outputs
  output logic reset_out_n,
  output logic sys_reset_n,
  output logic wake_pull_up,
  output logic boot_serial,
  output logic debug_trace_en,
  output logic debug_sync_req,
  output logic [3:0] trace_data_out
);

  // ==========================================================
  // Helpers
  function automatic logic [rst_cfg_pkg::CNT_W-1:0] sat_inc(
    input logic [rst_cfg_pkg::CNT_W-1:0] v);
    logic [rst_cfg_pkg::CNT_W-1:0] r;
    r = v;
    if (v != {rst_cfg_pkg::CNT_W{1'b1}})
    begin
      r = v + 8'h01;
    end
    return r;
  endfunction : sat_inc

  localparam logic [rst_cfg_pkg::CNT_W-1:0] QUAL_M1 = 8'(QUAL - 1);
  localparam logic [rst_cfg_pkg::CNT_W-1:0] GL_MIN = 8'(rst_cfg_pkg::GLITCH_MIN_CYC);
  localparam logic [rst_cfg_pkg::CNT_W-1:0] DLY_M1 = 8'(rst_cfg_pkg::RESET_OUT_N_DELAY_CYC - 1);
  localparam logic [rst_cfg_pkg::CNT_W-1:0] LEN_M1 = 8'(LEN - 1);
  localparam logic [rst_cfg_pkg::CNT_W-1:0] WAKE_AT = 8'(LEN - 1 - rst_cfg_pkg::WAKE_LEAD_CYC);

  // ==========================================================
  // Pin synchronisers
  rst_cfg_pkg::pins_t s1_reg;
  rst_cfg_pkg::pins_t s2_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // Oscillator status resets low, so the trace bit cannot drop before the pin reports stable.
      s1_reg <= 5'h10;
      s2_reg <= 5'h10;
    end
    else if (ce)
    begin
      s1_reg <= {reset_in_n, wake_pull_strap, boot_cfg_strap, debug_event_in, osc_stable_in};
      s2_reg <= s1_reg;
    end
  end

  logic rst_low;
  assign rst_low = !s2_reg.rst_n;

  // ==========================================================
  // Low-run counter and glitch detection
  logic [rst_cfg_pkg::CNT_W-1:0] low_cnt_reg;
  logic qualified;
  logic glitch_set;
  assign qualified = rst_low && (low_cnt_reg >= QUAL_M1);
  assign glitch_set = !rst_low && (low_cnt_reg > GL_MIN) && (low_cnt_reg <= QUAL_M1);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      low_cnt_reg <= 8'h00;
    end
    else if (ce)
    begin
      low_cnt_reg <= rst_low ? sat_inc(low_cnt_reg) : 8'h00;
    end
  end

  // ==========================================================
  // APB decode
  logic setup;
  logic wr_en;
  logic ack_reg;
  logic err_reg;
  logic sw_sys;
  logic sw_ext;
  logic glitch_clr;
  assign setup = psel && !penable;
  assign pready = psel && penable && ack_reg && ce;
  assign pslverr = pready && err_reg;
  assign wr_en = pready && pwrite && !err_reg;
  assign sw_sys = wr_en && (paddr == rst_cfg_pkg::CTRL_OFF) && pwdata[rst_cfg_pkg::C_SW_SYS];
  assign sw_ext = wr_en && (paddr == rst_cfg_pkg::CTRL_OFF) && pwdata[rst_cfg_pkg::C_SW_EXT];
  assign glitch_clr = wr_en && (paddr == rst_cfg_pkg::STATUS_OFF) && pwdata[rst_cfg_pkg::B_GLITCH];

  // ==========================================================
  // Reset sequencer
  rst_cfg_pkg::seq_t state_reg;
  rst_cfg_pkg::src_t src_reg;
  logic [rst_cfg_pkg::CNT_W-1:0] cnt_reg;
  logic reset_out_n_reg;
  logic sys_reset_n_reg;
  logic leaving;
  assign leaving = (state_reg == rst_cfg_pkg::ST_ASSERT) && (cnt_reg == LEN_M1) && !qualified;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= rst_cfg_pkg::ST_DELAY;
      src_reg <= rst_cfg_pkg::SRC_POR;
      cnt_reg <= 8'h00;
      reset_out_n_reg <= 1'b1;
      sys_reset_n_reg <= 1'b0;
    end
    else if (ce)
    begin
      case (state_reg)
        rst_cfg_pkg::ST_IDLE:
        begin
          if (qualified || dbg_port_reset_req || sw_sys || sw_ext)
          begin
            state_reg <= rst_cfg_pkg::ST_DELAY;
            cnt_reg <= 8'h00;
            sys_reset_n_reg <= 1'b0;
            if (qualified)
              src_reg <= rst_cfg_pkg::SRC_EXT;
            else if (dbg_port_reset_req)
              src_reg <= rst_cfg_pkg::SRC_DBG;
            else if (sw_sys)
              src_reg <= rst_cfg_pkg::SRC_SW_SYS;
            else
              src_reg <= rst_cfg_pkg::SRC_SW_EXT;
          end
        end
        rst_cfg_pkg::ST_DELAY:
        begin
          if (qualified)
          begin
            cnt_reg <= 8'h00;
            src_reg <= rst_cfg_pkg::SRC_EXT;
          end
          else if (cnt_reg == DLY_M1)
          begin
            // The pin follows the start of reset by the delay count.
            state_reg <= rst_cfg_pkg::ST_ASSERT;
            cnt_reg <= 8'h00;
            reset_out_n_reg <= 1'b0;
          end
          else
          begin
            cnt_reg <= sat_inc(cnt_reg);
          end
        end
        rst_cfg_pkg::ST_ASSERT:
        begin
          if (qualified)
          begin
            // The pin stays low; only the hold time starts over.
            cnt_reg <= 8'h00;
            src_reg <= rst_cfg_pkg::SRC_EXT;
          end
          else if (leaving)
          begin
            state_reg <= rst_cfg_pkg::ST_IDLE;
            reset_out_n_reg <= 1'b1;
            sys_reset_n_reg <= 1'b1;
          end
          else
          begin
            cnt_reg <= sat_inc(cnt_reg);
          end
        end
        default:
        begin
          state_reg <= rst_cfg_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign reset_out_n = reset_out_n_reg;
  assign sys_reset_n = sys_reset_n_reg;

  // ==========================================================
  // Strap and debug latches
  logic wake_reg;
  logic boot_reg;
  logic dbg_en_reg;
  logic wake_take;
  assign wake_take = (state_reg == rst_cfg_pkg::ST_ASSERT) && (cnt_reg == WAKE_AT) && !qualified
    && (src_reg != rst_cfg_pkg::SRC_DBG) && (src_reg != rst_cfg_pkg::SRC_SW_EXT);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wake_reg <= rst_cfg_pkg::WAKE_RST;
      boot_reg <= rst_cfg_pkg::BOOT_RST;
      dbg_en_reg <= rst_cfg_pkg::DBG_RST;
    end
    else if (ce)
    begin
      if (wake_take)
        wake_reg <= s2_reg.wake;
      if (state_reg == rst_cfg_pkg::ST_ASSERT)
        boot_reg <= s2_reg.boot;
      if (leaving)
        dbg_en_reg <= s2_reg.evt;
    end
  end

  assign wake_pull_up = wake_reg;
  assign boot_serial = boot_reg;
  assign debug_trace_en = dbg_en_reg;

  // ==========================================================
  // Debug event and oscillator indication
  logic evt_prev_reg;
  logic sync_reg;
  logic por_pend_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      evt_prev_reg <= 1'b0;
      sync_reg <= 1'b0;
      por_pend_reg <= 1'b1;
    end
    else if (ce)
    begin
      evt_prev_reg <= s2_reg.evt;
      sync_reg <= (state_reg == rst_cfg_pkg::ST_IDLE) && s2_reg.evt && !evt_prev_reg;
      if (s2_reg.osc)
        por_pend_reg <= 1'b0;
    end
  end

  assign debug_sync_req = sync_reg;
  assign trace_data_out = {3'h0, por_pend_reg};

  // ==========================================================
  // Status, glitch flag and read data
  logic glitch_reg;
  logic [31:0] prdata_reg;
  logic [31:0] status;
  always_comb
  begin
    status = 32'h0000_0000;
    status[rst_cfg_pkg::B_WAKE] = wake_reg;
    status[rst_cfg_pkg::B_BOOT] = boot_reg;
    status[rst_cfg_pkg::B_DBG] = dbg_en_reg;
    status[rst_cfg_pkg::B_GLITCH] = glitch_reg;
    status[rst_cfg_pkg::B_SRC +: 3] = src_reg;
    status[rst_cfg_pkg::B_OSC] = !por_pend_reg;
    status[rst_cfg_pkg::B_BUSY] = (state_reg != rst_cfg_pkg::ST_IDLE);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      glitch_reg <= 1'b0;
    end
    else if (ce)
    begin
      // A spike ending in the clearing cycle is kept.
      if (glitch_set)
        glitch_reg <= 1'b1;
      else if (glitch_clr)
        glitch_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end
    else if (ce)
    begin
      if (setup)
      begin
        ack_reg <= 1'b1;
        err_reg <= (paddr != rst_cfg_pkg::STATUS_OFF) && (paddr != rst_cfg_pkg::CTRL_OFF);
        prdata_reg <= (paddr == rst_cfg_pkg::STATUS_OFF) ? status : 32'h0000_0000;
      end
      else if (pready)
      begin
        ack_reg <= 1'b0;
      end
    end
  end

  assign prdata = prdata_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ext_qualify_a: assert property (
    ce && state_reg == rst_cfg_pkg::ST_IDLE && rst_low && low_cnt_reg == QUAL_M1
    |=> state_reg == rst_cfg_pkg::ST_DELAY && !sys_reset_n)
    else $error("qualified reset input did not start the sequence");
  restart_seq_a: assert property (
    ce && state_reg != rst_cfg_pkg::ST_IDLE && qualified |=> cnt_reg == 8'h00)
    else $error("reset input during reset did not restart");
  glitch_flag_a: assert property (
    ce && !rst_low && low_cnt_reg == 8'h03 |=> glitch_reg)
    else $error("spike of three cycles not flagged");
  out_low_a: assert property (
    ce && state_reg == rst_cfg_pkg::ST_DELAY && cnt_reg == DLY_M1 && !qualified
    |=> !reset_out_n && !sys_reset_n)
    else $error("reset output not driven low");
  out_delay_a: assert property (
    $fell(sys_reset_n) |-> reset_out_n)
    else $error("reset output asserted with reset start");
  wake_sample_a: assert property (
    ce && wake_take |=> wake_pull_up == $past(s2_reg.wake))
    else $error("wake strap not latched at its sample point");
  wake_keep_a: assert property (
    ce && state_reg == rst_cfg_pkg::ST_ASSERT && (src_reg == rst_cfg_pkg::SRC_DBG ||
    src_reg == rst_cfg_pkg::SRC_SW_EXT) |=> $stable(wake_pull_up))
    else $error("wake strap changed on excluded source");
  boot_sample_a: assert property (
    ce && !reset_out_n |=> boot_serial == $past(s2_reg.boot))
    else $error("boot strap not sampled during reset output");
  dbg_latch_a: assert property (
    ce && leaving |=> reset_out_n && debug_trace_en == $past(s2_reg.evt))
    else $error("debug enable not latched at negation");
  osc_flag_a: assert property (
    ce && por_pend_reg && !s2_reg.osc |=> trace_data_out[0])
    else $error("trace bit dropped before oscillator stable");

  ext_reset_c: cover property (state_reg == rst_cfg_pkg::ST_IDLE ##1 state_reg == rst_cfg_pkg::ST_DELAY
    && src_reg == rst_cfg_pkg::SRC_EXT);
  restart_c: cover property (state_reg == rst_cfg_pkg::ST_ASSERT && qualified && cnt_reg != 8'h00);
  glitch_c: cover property ($rose(glitch_reg));
  sync_c: cover property (debug_sync_req && debug_trace_en);

endmodule : reset_pin_and_config_latch

`default_nettype wire

//--- dv/board_model.sv
// Board side of the reset block: reset supervisor, strap resistors and oscillator status.
// Assumes the bench sets the strap values and calls the tasks from its own thread.
`timescale 1ns/10ps
`default_nettype none
module board_model (
  // Clock and device output
  input wire logic pclk,
  input wire logic reset_out_n,
  // Pins driven by the board
  output logic reset_in_n,
  output logic wake_pull_strap,
  output logic boot_cfg_strap,
  output logic debug_event_in,
  output logic osc_stable_in
);
  logic wake_val = 1'b1;
  logic boot_val = 1'b1;
  initial
  begin
    reset_in_n = 1'b1;
    debug_event_in = 1'b1;
    osc_stable_in = 1'b0;
  end
  // ==========================================================
  // Straps
  // The straps are valid only while the reset output is low; outside it the inverse shows, so a late sample is caught.
  always_comb
  begin
    wake_pull_strap = reset_out_n ? ~wake_val : wake_val;
    boot_cfg_strap = reset_out_n ? ~boot_val : boot_val;
  end
  // ==========================================================
  // Pulses on the reset and debug event pins
  task automatic pulse(input int n);
    @(posedge pclk);
    reset_in_n <= 1'b0;
    repeat (n) @(posedge pclk);
    reset_in_n <= 1'b1;
  endtask : pulse
  task automatic evt(input int n);
    @(posedge pclk);
    debug_event_in <= 1'b1;
    repeat (n) @(posedge pclk);
    debug_event_in <= 1'b0;
  endtask : evt
endmodule : board_model
`default_nettype wire

//--- dv/reset_pin_and_config_latch_tb.sv
// Self-checking bench for the reset pin and strap latch.
// Assumes board_model stands for the board and APB reaches the two registers.
`timescale 1ns/10ps
`default_nettype none
module reset_pin_and_config_latch_tb;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, rd_err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic reset_in_n, wake_pull_strap, boot_cfg_strap, debug_event_in, osc_stable_in, dbg_port_reset_req;
  logic reset_out_n, sys_reset_n, wake_pull_up, boot_serial, debug_trace_en, debug_sync_req;
  logic [3:0] trace_data_out;
  int fail_count, num_checks, lo;
  reset_pin_and_config_latch u_reset_pin_and_config_latch (.pclk, .presetn, .ce, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .reset_in_n, .wake_pull_strap, .boot_cfg_strap,
    .debug_event_in, .osc_stable_in, .dbg_port_reset_req, .reset_out_n, .sys_reset_n, .wake_pull_up,
    .boot_serial, .debug_trace_en, .debug_sync_req, .trace_data_out);
  board_model u_board_model (.pclk, .reset_out_n, .reset_in_n, .wake_pull_strap, .boot_cfg_strap,
    .debug_event_in, .osc_stable_in);
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // ==========================================================
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Counts the cycles for which the reset output stays low.
  task automatic seq();
    lo = 0;
    while (reset_out_n !== 1'b0)
      @(negedge pclk);
    while (reset_out_n !== 1'b1)
    begin
      @(negedge pclk);
      lo++;
    end
  endtask : seq
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  // ==========================================================
  // Scenarios
  task automatic t_por();
    seq();
    chk("por low cycles", 16, lo);
    chk("sys reset", 1, sys_reset_n);
    chk("wake pull", 1, wake_pull_up);
    chk("boot serial", 1, boot_serial);
    chk("trace enable", 1, debug_trace_en);
    chk("trace osc", 4'h1, trace_data_out);
    u_board_model.osc_stable_in <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("trace osc", 4'h0, trace_data_out);
    apb(1'b0, 8'h00, 32'h0);
    chk("status", 32'h87, rd);
    $display("test por done");
  endtask : t_por
  task automatic t_glitch();
    u_board_model.pulse(9);
    repeat (8) @(posedge pclk);
    chk("no reset", 1, sys_reset_n);
    apb(1'b0, 8'h00, 32'h0);
    chk("glitch", 1, rd[3]);
    apb(1'b1, 8'h00, 32'h8);
    u_board_model.pulse(2);
    repeat (8) @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0);
    chk("short spike", 0, rd[3]);
    u_board_model.pulse(3);
    repeat (8) @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0);
    chk("three cycle spike", 1, rd[3]);
    $display("test glitch done");
  endtask : t_glitch
  task automatic t_ext();
    u_board_model.wake_val = 1'b0;
    u_board_model.boot_val = 1'b0;
    u_board_model.debug_event_in <= 1'b0;
    fork
      u_board_model.pulse(10);
      begin
        while (sys_reset_n !== 1'b0)
          @(negedge pclk);
        chk("out at start", 1, reset_out_n);
        seq();
      end
    join
    chk("ext low cycles", 16, lo);
    chk("wake pull", 0, wake_pull_up);
    chk("boot flash", 0, boot_serial);
    chk("trace enable", 0, debug_trace_en);
    apb(1'b0, 8'h00, 32'h0);
    chk("status", 32'h90, rd & 32'hfffffff7);
    // A second qualified low while the output is held restarts the hold time.
    fork
      begin
        u_board_model.pulse(10);
        while (reset_out_n !== 1'b0)
          @(negedge pclk);
        u_board_model.pulse(10);
      end
      seq();
    join
    chk("restart", 1, lo > 20);
    $display("test ext done");
  endtask : t_ext
  task automatic sw_case(input int kind, input logic w, input logic b, input logic exp_w, input logic [2:0] src);
    u_board_model.wake_val = w;
    u_board_model.boot_val = b;
    if (kind == 2)
    begin
      @(posedge pclk);
      dbg_port_reset_req <= 1'b1;
      @(posedge pclk);
      dbg_port_reset_req <= 1'b0;
    end
    else
      apb(1'b1, 8'h04, kind == 0 ? 32'h1 : 32'h2);
    seq();
    chk("low cycles", 16, lo);
    chk("wake latch", exp_w, wake_pull_up);
    chk("boot latch", b, boot_serial);
    apb(1'b0, 8'h00, 32'h0);
    chk("source", src, rd[6:4]);
    $display("test sw case %0d done", kind);
  endtask : sw_case
  task automatic t_misc();
    int n;
    n = 0;
    fork
      u_board_model.evt(3);
      repeat (12)
      begin
        @(negedge pclk);
        if (debug_sync_req === 1'b1)
          n++;
      end
    join
    chk("sync pulses", 1, n);
    apb(1'b0, 8'h04, 32'h0);
    chk("ctrl read", 0, rd);
    chk("ctrl err", 0, rd_err);
    apb(1'b1, 8'h0c, 32'h3);
    chk("unmapped err", 1, rd_err);
    repeat (6) @(posedge pclk);
    chk("unmapped no reset", 1, sys_reset_n);
    $display("test misc done");
  endtask : t_misc
  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    dbg_port_reset_req = 1'b0;
    fail_count = 0;
    num_checks = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_por();
    t_glitch();
    t_ext();
    sw_case(1, 1'b1, 1'b1, 1'b0, 3'h3);
    sw_case(0, 1'b1, 1'b0, 1'b1, 3'h2);
    sw_case(2, 1'b0, 1'b1, 1'b1, 3'h4);
    t_misc();
    end_of_test();
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    end_of_test();
  end
endmodule : reset_pin_and_config_latch_tb
`default_nettype wire
